// ### pvsr_pkg.sv
package pvsr_pkg;

    // ----------------------------------------------------------------
    // command codes and pages
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS = 8'h7a;
    localparam logic [7:0] PAGE_RAIL_A = 8'h00;
    localparam logic [7:0] PAGE_RAIL_B = 8'h01;
    localparam logic [7:0] PAGE_ALL = 8'hff;
    localparam int RAILS = 2;
    localparam int SYNC_STAGES = 3;

    // ----------------------------------------------------------------
    // output voltage status byte layout
    // ----------------------------------------------------------------
    localparam int VS_OVF_BIT = 7;
    localparam int VS_UVF_BIT = 4;
    localparam int VS_LIMIT_BIT = 3;
    localparam logic [7:0] VS_WRITABLE_MASK = 8'h98;
    localparam logic [7:0] VS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // summary word layout
    // ----------------------------------------------------------------
    localparam int SW_OUTPUT_VOLTAGE_SUMMARY_BIT = 15;
    localparam int SW_OUTPUT_CURRENT_SUMMARY_BIT = 14;
    localparam int SW_INPUT_BIT = 13;
    localparam int SW_VENDOR_BIT = 12;
    localparam int SW_POWER_GOOD_LIVE_BIT = 11;
    localparam int SW_OFF_BIT = 6;
    localparam int SW_OV_BIT = 5;
    localparam int SW_OC_BIT = 4;
    localparam int SW_INPUT_UNDERVOLTAGE_FLAG_BIT = 3;
    localparam int SW_TEMP_BIT = 2;
    localparam int SW_CML_BIT = 1;
    localparam int SW_OTHER_BIT = 0;
    localparam logic [15:0] SW_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // detail bits taken from neighbouring status registers
    // ----------------------------------------------------------------
    localparam int OUTPUT_CURRENT_SUMMARY_OCF_BIT = 7;
    localparam int OUTPUT_CURRENT_SUMMARY_OCW_BIT = 5;
    localparam int INPUT_LOCKOUT_BIT = 3;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic word;
        logic [7:0] code;
        logic [7:0] page;
        logic [7:0] data;
    } pvsr_req_s;

    typedef struct packed {
        logic done;
        logic invalid;
        logic [15:0] data;
    } pvsr_rsp_s;

    typedef struct packed {
        logic ov_evt;
        logic uv_evt;
        logic limit_evt;
        logic not_powered;
        logic [7:0] output_current_status;
    } pvsr_rail_in_s;

    typedef struct packed {
        logic [7:0] input_status;
        logic [7:0] vendor_status;
        logic temp_flag;
        logic cml_flag;
        logic other_flag;
    } pvsr_shared_in_s;

endpackage : pvsr_pkg

// ### pvsr_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pvsr_sync
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic raw,
    output logic level
);
    import pvsr_pkg::*;

    logic [SYNC_STAGES-1:0] stage;

    // ----------------------------------------------------------------
    // three-stage capture
    // ----------------------------------------------------------------
    // only stage 1 reads stage 0, keeping metastability contained
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage <= '0;
        end
        else
        begin
            stage <= {stage[SYNC_STAGES-2:0], raw};
        end
    end

    // accept a change only once the last two stages agree
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level <= 1'b0;
        end
        else if (stage[1] == stage[2])
        begin
            level <= stage[2];
        end
    end

endmodule : pvsr_sync

`default_nettype wire

// ### pvsr_status.sv
`timescale 1ns/100ps
`default_nettype none

module pvsr_status
(
    input wire logic clock,
    input wire logic rst_n,
    input wire pvsr_pkg::pvsr_req_s req,
    output pvsr_pkg::pvsr_rsp_s rsp,
    input wire logic clear_faults,
    input wire pvsr_pkg::pvsr_rail_in_s [1:0] rail_in,
    input wire pvsr_pkg::pvsr_shared_in_s shared_in,
    input wire logic rail_a_ready_pin,
    input wire logic rail_b_ready_pin,
    output logic [1:0][7:0] output_voltage_status,
    output logic [1:0][15:0] summary_status_word
);
    import pvsr_pkg::*;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------

    // page value is one this block answers to
    function automatic logic page_known(input logic [7:0] page);
        page_known = (page == PAGE_RAIL_A) || (page == PAGE_RAIL_B) || (page == PAGE_ALL);
    endfunction : page_known

    // does a page reach a rail; the all-page reads rail A, writes all
    function automatic logic page_hits(input logic [7:0] page, input int rail, input logic wr);
        logic hit;
        hit = 1'b0;
        if (page == PAGE_ALL)
        begin
            hit = wr || (rail == 0);
        end
        else if ((rail == 0) && (page == PAGE_RAIL_A))
        begin
            hit = 1'b1;
        end
        else if ((rail == 1) && (page == PAGE_RAIL_B))
        begin
            hit = 1'b1;
        end
        page_hits = hit;
    endfunction : page_hits

    // ----------------------------------------------------------------
    // request classification
    // ----------------------------------------------------------------
    logic hit_word;
    logic hit_output_voltage_summary;
    logic word_read_ok;
    logic output_voltage_summary_read_ok;
    logic output_voltage_summary_write_ok;
    logic req_invalid;

    // shape checks on the two commands owned here
    assign hit_word = req.valid && (req.code == CMD_SUMMARY_WORD);
    assign hit_output_voltage_summary = req.valid && (req.code == CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS);
    assign word_read_ok = hit_word && !req.write && req.word && page_known(req.page);
    assign output_voltage_summary_read_ok = hit_output_voltage_summary && !req.write && !req.word && page_known(req.page);
    assign output_voltage_summary_write_ok = hit_output_voltage_summary && req.write && !req.word && page_known(req.page);
    // any write to the summary word falls here and touches nothing
    assign req_invalid = (hit_word && !word_read_ok)
        || (hit_output_voltage_summary && !output_voltage_summary_read_ok && !output_voltage_summary_write_ok);

    // ----------------------------------------------------------------
    // ready pin capture
    // ----------------------------------------------------------------
    logic [1:0] ready_raw;
    logic [1:0] ready_level;

    assign ready_raw = {rail_b_ready_pin, rail_a_ready_pin};

    genvar gs;
    generate
        for (gs = 0; gs < RAILS; gs++)
        begin : g_sync
            pvsr_sync u_sync
            (
                .clock(clock),
                .rst_n(rst_n),
                .raw(ready_raw[gs]),
                .level(ready_level[gs])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // shared summary terms
    // ----------------------------------------------------------------
    logic input_any;
    logic vendor_any;
    logic input_lockout;

    // input and vendor detail is shared by both rails
    assign input_any = |shared_in.input_status;
    assign vendor_any = |shared_in.vendor_status;
    assign input_lockout = shared_in.input_status[INPUT_LOCKOUT_BIT];

    // ----------------------------------------------------------------
    // per-rail flags and summary
    // ----------------------------------------------------------------
    logic [1:0][7:0] vs_flags;
    logic [1:0][15:0] next_summary;

    genvar gr;
    generate
        for (gr = 0; gr < RAILS; gr++)
        begin : g_rail
            logic [7:0] set_bits;
            logic [7:0] clr_bits;
            logic [7:0] output_current_summary;

            // conditions present this cycle
            assign set_bits[VS_OVF_BIT] = rail_in[gr].ov_evt;
            assign set_bits[VS_UVF_BIT] = rail_in[gr].uv_evt;
            assign set_bits[VS_LIMIT_BIT] = rail_in[gr].limit_evt;
            assign set_bits[6:5] = 2'b00;
            assign set_bits[2:0] = 3'b000;

            // clear_faults, or ones written to writable bits of a page that reaches this rail
            assign clr_bits = (clear_faults ? VS_WRITABLE_MASK : 8'h00)
                | ((output_voltage_summary_write_ok && page_hits(req.page, gr, 1'b1))
                    ? (req.data & VS_WRITABLE_MASK) : 8'h00);

            // set wins over clear, so a persisting condition stays flagged
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    vs_flags[gr] <= VS_RESET;
                end
                else
                begin
                    vs_flags[gr] <= ((vs_flags[gr] & ~clr_bits) | set_bits) & VS_WRITABLE_MASK;
                end
            end

            assign output_current_summary = rail_in[gr].output_current_status;

            // summary built from detail so it clears with it
            always_comb
            begin
                next_summary[gr] = SW_RESET;
                next_summary[gr][SW_OUTPUT_VOLTAGE_SUMMARY_BIT] = |vs_flags[gr];
                next_summary[gr][SW_OUTPUT_CURRENT_SUMMARY_BIT] = |output_current_summary;
                next_summary[gr][SW_INPUT_BIT] = input_any;
                next_summary[gr][SW_VENDOR_BIT] = vendor_any;
                next_summary[gr][SW_POWER_GOOD_LIVE_BIT] = !ready_level[gr];
                next_summary[gr][SW_OFF_BIT] = rail_in[gr].not_powered;
                next_summary[gr][SW_OV_BIT] = vs_flags[gr][VS_OVF_BIT];
                next_summary[gr][SW_OC_BIT] = output_current_summary[OUTPUT_CURRENT_SUMMARY_OCF_BIT];
                next_summary[gr][SW_INPUT_UNDERVOLTAGE_FLAG_BIT] = input_lockout;
                next_summary[gr][SW_TEMP_BIT] = shared_in.temp_flag;
                next_summary[gr][SW_CML_BIT] = shared_in.cml_flag;
                next_summary[gr][SW_OTHER_BIT] = vs_flags[gr][VS_UVF_BIT]
                    || output_current_summary[OUTPUT_CURRENT_SUMMARY_OCW_BIT]
                    || shared_in.other_flag;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // observation outputs
    // ----------------------------------------------------------------
    // both ports lag the live state by one cycle; reads use the live value
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            summary_status_word <= '0;
            output_voltage_status <= '0;
        end
        else
        begin
            summary_status_word <= next_summary;
            output_voltage_status <= vs_flags;
        end
    end

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    logic [15:0] next_data;

    // unreached bits of the byte read sit at zero
    always_comb
    begin
        next_data = 16'h0000;
        if (word_read_ok)
        begin
            next_data = page_hits(req.page, 0, 1'b0) ? next_summary[0] : next_summary[1];
        end
        else if (output_voltage_summary_read_ok)
        begin
            next_data = {8'h00, page_hits(req.page, 0, 1'b0) ? vs_flags[0] : vs_flags[1]};
        end
    end

    // ----------------------------------------------------------------
    // answer register
    // ----------------------------------------------------------------
    // foreign command codes get no answer so the engine can route them
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp <= '0;
        end
        else
        begin
            rsp.done <= hit_word || hit_output_voltage_summary;
            rsp.invalid <= req_invalid;
            rsp.data <= next_data;
        end
    end

endmodule : pvsr_status

`default_nettype wire

// ### pvsr_status_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module pvsr_status_monitor
(
    input wire logic clock,
    input wire logic rst_n,
    input wire pvsr_pkg::pvsr_req_s req,
    input wire pvsr_pkg::pvsr_rsp_s rsp,
    input wire logic clear_faults,
    input wire pvsr_pkg::pvsr_rail_in_s [1:0] rail_in,
    input wire pvsr_pkg::pvsr_shared_in_s shared_in,
    input wire logic rail_a_ready_pin,
    input wire logic rail_b_ready_pin,
    input wire logic [1:0][7:0] output_voltage_status,
    input wire logic [1:0][15:0] summary_status_word
);
    import pvsr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // summary word and voltage status checks
    // ----------------------------------------------------------------
    // $past guards skip the first edge, which still sees reset values
    a_zero_bits: assert property (summary_status_word[0][10:7] == 4'h0
        && summary_status_word[1][10:7] == 4'h0) else $error("summary unsupported bits set");
    a_vs_reserved: assert property (((output_voltage_status[0] | output_voltage_status[1])
        & ~VS_WRITABLE_MASK) == 8'h00) else $error("voltage status reserved bits set");
    a_done_follows: assert property ($past(rst_n) |-> rsp.done == $past(req.valid
        && (req.code == CMD_SUMMARY_WORD || req.code == CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS))) else $error("done not one cycle after");
    a_summary_write_bad: assert property (req.valid && req.write && req.code == CMD_SUMMARY_WORD
        |=> rsp.invalid && rsp.data == 16'h0000) else $error("summary write not refused");
    a_output_voltage_summary_map: assert property (summary_status_word[0][15] == |output_voltage_status[0]
        && summary_status_word[0][5] == output_voltage_status[0][7]) else $error("voltage summary mismatch");
    a_output_current_summary_map: assert property ($past(rst_n) |-> summary_status_word[1][14]
        == $past(|rail_in[1].output_current_status)
        && summary_status_word[1][4] == $past(rail_in[1].output_current_status[7])) else $error("current summary mismatch");
    a_off_live: assert property ($past(rst_n)
        |-> summary_status_word[0][6] == $past(rail_in[0].not_powered)) else $error("off bit not live");
    a_shared_map: assert property ($past(rst_n) |-> summary_status_word[1][3:1]
        == $past({shared_in.input_status[3], shared_in.temp_flag, shared_in.cml_flag})) else $error("shared bits mismatch");
    a_power_good_live_live: assert property ($stable(rail_b_ready_pin)[*6]
        |-> summary_status_word[1][11] == !rail_b_ready_pin) else $error("ready bit not live");
    a_event_sets: assert property ($past(rst_n) && rail_in[1].ov_evt
        |-> ##2 output_voltage_status[1][7]) else $error("overvoltage flag not latched");
endmodule : pvsr_status_monitor

bind pvsr_status pvsr_status_monitor mon_u (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp),
    .clear_faults(clear_faults), .rail_in(rail_in), .shared_in(shared_in), .rail_a_ready_pin(rail_a_ready_pin),
    .rail_b_ready_pin(rail_b_ready_pin), .output_voltage_status(output_voltage_status),
    .summary_status_word(summary_status_word));

`default_nettype wire

// ### pvsr_host.sv
`timescale 1ns/100ps
`default_nettype none

module pvsr_host
(
    input wire logic clock,
    output var pvsr_pkg::pvsr_req_s req,
    input wire pvsr_pkg::pvsr_rsp_s rsp
);
    import pvsr_pkg::*;
    initial req = '0;

    // one transfer; bad flips the word flag to make a refused access
    task automatic xfer(input logic bad, input logic w, input logic [7:0] code, input logic [7:0] page,
        input logic [7:0] d, output pvsr_rsp_s r);
        @(posedge clock);
        #1 req = '{1'b1, w, (code == CMD_SUMMARY_WORD && !w) ^ bad, code, page, d};
        @(posedge clock);
        #1 r = rsp;
        req.valid = 1'b0;
        req.code = ~code; // idle code and data lines do not keep the last value
        req.data = ~d;
    endtask : xfer
endmodule : pvsr_host

`default_nettype wire

// ### test_pvsr_status.sv
`timescale 1ns/100ps
`default_nettype none

module test_pvsr_status;
    import pvsr_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clear_faults = 1'b0;
    logic [1:0] pin = 2'b11;
    pvsr_req_s req;
    pvsr_rsp_s rsp;
    pvsr_rsp_s r;
    pvsr_rail_in_s [1:0] rail_in = '0;
    pvsr_shared_in_s shared_in = '0;
    logic [1:0][7:0] vs;
    logic [1:0][15:0] sw;
    logic [7:0] vf [2] = '{8'h00, 8'h00}; // model of latched voltage flags
    logic [7:0] pg [3] = '{8'h00, 8'h01, 8'hff};
    int err_count = 0;
    int check_count = 0;
    int seed = 32'h1e028535;

    pvsr_status dut_u (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp), .clear_faults(clear_faults),
        .rail_in(rail_in), .shared_in(shared_in), .rail_a_ready_pin(pin[0]), .rail_b_ready_pin(pin[1]),
        .output_voltage_status(vs), .summary_status_word(sw));
    pvsr_host host_u (.clock(clock), .req(req), .rsp(rsp));

    initial forever #5 clock = ~clock;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] exp_word(input int k);
        exp_word = {|vf[k], |rail_in[k].output_current_status, |shared_in.input_status,
            |shared_in.vendor_status, !pin[k], 4'h0, rail_in[k].not_powered, vf[k][7],
            rail_in[k].output_current_status[7], shared_in.input_status[3], shared_in.temp_flag,
            shared_in.cml_flag, vf[k][4] | rail_in[k].output_current_status[5] | shared_in.other_flag};
    endfunction : exp_word

    // pages 00h, 01h and ffh; ffh answers for rail A
    task automatic read_all();
        for (int i = 0; i < 3; i++)
        begin
            host_u.xfer(0, 0, CMD_SUMMARY_WORD, pg[i], 8'h00, r);
            check("summary word", r, {2'b10, exp_word(i % 2)});
            if (i < 2) check("summary port", {2'b00, sw[i]}, {2'b00, exp_word(i)});
            host_u.xfer(0, 0, CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, pg[i], 8'h00, r);
            check("voltage status", r, {10'h200, vf[i % 2]});
            if (i < 2) check("voltage port", {10'h000, vs[i]}, {10'h000, vf[i]});
        end
    endtask : read_all

    task automatic pulse(input int k, input logic [2:0] ev);
        @(posedge clock);
        #1 {rail_in[k].ov_evt, rail_in[k].uv_evt, rail_in[k].limit_evt} = ev;
        @(posedge clock);
        #1 {rail_in[k].ov_evt, rail_in[k].uv_evt, rail_in[k].limit_evt} = 3'b000;
        vf[k] |= {ev[2], 2'b00, ev[1], ev[0], 3'b000};
    endtask : pulse

    task automatic clear_write(input logic [7:0] page, input logic [7:0] d);
        host_u.xfer(0, 1, CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, page, d, r);
        check("write reply", r, 18'h2_0000);
        for (int k = 0; k < 2; k++)
            if (page == 8'hff || page == k) vf[k] &= ~(d & VS_WRITABLE_MASK);
    endtask : clear_write

    task automatic clear_pulse();
        @(posedge clock);
        #1 clear_faults = 1'b1;
        @(posedge clock);
        #1 clear_faults = 1'b0;
    endtask : clear_pulse

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clock);
        read_all();
        $display("test reset done");
        // random conditions, events and write-one clears on a randomly chosen page
        repeat (12)
        begin
            {rail_in[0].not_powered, rail_in[1].not_powered, pin} = 4'($random(seed));
            rail_in[0].output_current_status = 8'($random(seed)) & 8'ha8;
            rail_in[1].output_current_status = 8'($random(seed)) & 8'ha8;
            shared_in = 19'($random(seed));
            pulse(1, 3'($random(seed)));
            pulse(0, 3'($random(seed)));
            clear_write(pg[$unsigned($random(seed)) % 3], 8'($random(seed)));
            read_all();
        end
        $display("test random done");
        // refused accesses leave every flag alone
        pulse(0, 3'b111);
        host_u.xfer(0, 1, CMD_SUMMARY_WORD, 8'h00, 8'hff, r);
        check("summary write", r, 18'h3_0000);
        host_u.xfer(1, 0, CMD_SUMMARY_WORD, 8'h00, 8'hff, r);
        check("summary byte read", r, 18'h3_0000);
        host_u.xfer(1, 1, CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 8'h00, 8'hff, r);
        check("voltage word write", r, 18'h3_0000);
        host_u.xfer(0, 0, CMD_OUTPUT_VOLTAGE_SUMMARY_STATUS, 8'h02, 8'h00, r);
        check("bad page", r, 18'h3_0000);
        host_u.xfer(0, 0, 8'h7b, 8'h00, 8'h00, r);
        check("other code", r, 18'h0_0000);
        read_all();
        $display("test refused done");
        // a present condition outlasts both kinds of clear
        @(posedge clock);
        #1 rail_in[0].ov_evt = 1'b1;
        clear_write(8'h00, 8'h80);
        vf[0][7] = 1'b1;
        clear_pulse();
        @(posedge clock);
        #1 rail_in[0].ov_evt = 1'b0;
        vf[0] = 8'h80;
        vf[1] = 8'h00;
        read_all();
        clear_pulse();
        vf[0] = 8'h00;
        read_all();
        $display("test clear done");
        // a reset in mid-run drops every latched flag and restarts the ready capture
        pulse(1, 3'b111);
        @(posedge clock);
        #1 rst_n = 1'b0;
        @(posedge clock);
        #1 rst_n = 1'b1;
        vf[0] = 8'h00;
        vf[1] = 8'h00;
        repeat (6) @(posedge clock);
        read_all();
        $display("test midrun reset done");
        print_verdict();
    end

    // hang guard
    initial
    begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule : test_pvsr_status

`default_nettype wire
